/* rtl/sbl_pkg.sv */
// Purpose: shared constants and types for the bank command legality block
// Assumes: 100 MHz system clock, four banks
// Notes: wait counts are derived from times in ns, rounded up
package sbl_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int NUM_BANKS = 4;
    localparam int CNT_W = 8;
    // least times in ns, turned into whole cycles (rounded up, min 1)
    localparam int PRECHARGE_WAIT_NS = 30;
    localparam int ACT_TO_ACCESS_WAIT_NS = 30;
    localparam int REFRESH_CYCLE_WAIT_NS = 60;
    localparam int MODE_LOAD_WAIT_NS = 20;
    localparam int SELF_REF_EXIT_WAIT_NS = 80;
    localparam int PRECHARGE_WAIT_CYC =
        (PRECHARGE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACT_TO_ACCESS_WAIT_CYC =
        (ACT_TO_ACCESS_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REFRESH_CYCLE_WAIT_CYC =
        (REFRESH_CYCLE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MODE_LOAD_WAIT_CYC =
        (MODE_LOAD_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SELF_REF_EXIT_WAIT_CYC =
        (SELF_REF_EXIT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // address bit that asks for auto precharge / all banks
    localparam int AP_BIT = 10;
    localparam int ADDR_W = 13;

    // decoded command (row, column, write strobes with select low)
    typedef enum logic [3:0] {
        SBL_CMD_NOP   = 4'h0,
        SBL_CMD_ACT   = 4'h1,
        SBL_CMD_REF   = 4'h2,
        SBL_CMD_LMR   = 4'h3,
        SBL_CMD_PRE   = 4'h4,
        SBL_CMD_READ  = 4'h5,
        SBL_CMD_WRITE = 4'h6,
        SBL_CMD_BST   = 4'h7
    } sbl_cmd_t;

    // per-bank state, one-hot
    typedef enum logic [7:0] {
        SBL_IDLE  = 8'h01,
        SBL_ACTV  = 8'h02,
        SBL_ROWA  = 8'h04,
        SBL_RD    = 8'h08,
        SBL_WR    = 8'h10,
        SBL_RDAP  = 8'h20,
        SBL_WRAP  = 8'h40,
        SBL_PRECH = 8'h80
    } sbl_bank_st_t;

    // device-wide state, one-hot
    typedef enum logic [3:0] {
        SBL_G_RUN  = 4'h1,
        SBL_G_REF  = 4'h2,
        SBL_G_MODE = 4'h4,
        SBL_G_XSR  = 4'h8
    } sbl_glob_st_t;

    // command bus as seen on the pins
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bank;
        logic [ADDR_W-1:0] addr;
    } sbl_cmd_bus_t;

    // wait times in cycles, one set shared by all banks and the device-wide state
    typedef struct packed {
        logic [CNT_W-1:0] precharge_wait;
        logic [CNT_W-1:0] activate_to_access_wait;
        logic [CNT_W-1:0] refresh_cycle_wait;
        logic [CNT_W-1:0] mode_load_wait;
        logic [CNT_W-1:0] self_refresh_exit_wait;
    } sbl_timing_t;
endpackage

/* rtl/sbl_bank_legality.sv */
// Purpose: per-bank command decode and state tracking for a 4-bank DRAM
// Assumes: command pins synchronous to I_SYS_CLK, wait counts >= 1
// Notes: illegal commands from the controller are ignored, not flagged
module sbl_bank_legality
    import sbl_pkg::*;
#(
    parameter int BURST_LEN = 4
) (
    // clock and reset
    input wire logic I_SYS_CLK,
    input wire logic I_RSTN,
    // command bus from the memory controller
    input wire logic I_CKE,
    input wire sbl_cmd_bus_t I_CMD,
    input wire logic I_SELF_REF_EXIT,
    input wire sbl_timing_t I_TIMING,
    // state view
    output logic [NUM_BANKS*8-1:0] O_BANK_STATE,
    output logic O_ALL_IDLE,
    output logic O_BUSY,
    output logic O_CMD_TAKEN,
    output logic [3:0] O_CMD_CODE
);
    logic cke_reg;
    logic cke_next;
    logic cmd_ok;
    sbl_cmd_t cmd;
    logic ap;
    sbl_glob_st_t g_reg;
    sbl_glob_st_t g_next;
    logic [CNT_W-1:0] gcnt_reg;
    logic [CNT_W-1:0] gcnt_next;
    logic [1:0] last_bank_reg;
    logic [1:0] last_bank_next;
    logic last_valid_reg;
    logic last_valid_next;
    logic taken_reg;
    logic taken_next;
    sbl_cmd_t code_reg;
    sbl_cmd_t code_next;
    sbl_bank_st_t st_reg [NUM_BANKS];
    sbl_bank_st_t st_next [NUM_BANKS];
    logic [CNT_W-1:0] cnt_reg [NUM_BANKS];
    logic [CNT_W-1:0] cnt_next [NUM_BANKS];
    logic [NUM_BANKS-1:0] idle_vec;
    logic burst_start;

    assign ap = I_CMD.addr[AP_BIT];

    // strobe decode; deselect reads as no-operation
    always_comb begin
        cmd = SBL_CMD_NOP;
        if (!I_CMD.cs_n) begin
            unique case ({I_CMD.ras_n, I_CMD.cas_n, I_CMD.we_n})
                3'h3: cmd = SBL_CMD_ACT;
                3'h1: cmd = SBL_CMD_REF;
                3'h0: cmd = SBL_CMD_LMR;
                3'h2: cmd = SBL_CMD_PRE;
                3'h5: cmd = SBL_CMD_READ;
                3'h4: cmd = SBL_CMD_WRITE;
                3'h6: cmd = SBL_CMD_BST;
                3'h7: cmd = SBL_CMD_NOP;
            endcase
        end
    end

    // commands count only with clock enable high on both edges
    // and outside refresh, mode load and self-refresh exit
    assign cmd_ok = cke_reg && I_CKE && (g_reg == SBL_G_RUN);
    assign burst_start = cmd_ok &&
        (cmd == SBL_CMD_READ || cmd == SBL_CMD_WRITE) &&
        (st_reg[I_CMD.bank] == SBL_ROWA || st_reg[I_CMD.bank] == SBL_RD ||
         st_reg[I_CMD.bank] == SBL_WR);

    // device-wide state and last burst tracking
    always_comb begin
        cke_next = I_CKE;
        g_next = g_reg;
        gcnt_next = gcnt_reg;
        last_bank_next = last_bank_reg;
        last_valid_next = last_valid_reg;
        taken_next = 1'b0;
        code_next = SBL_CMD_NOP;
        if (cmd_ok && cmd != SBL_CMD_NOP) begin
            taken_next = 1'b1;
            code_next = cmd;
        end
        unique case (g_reg)
            SBL_G_RUN: begin
                if (I_SELF_REF_EXIT) begin
                    g_next = SBL_G_XSR;
                    gcnt_next = I_TIMING.self_refresh_exit_wait;
                end else if (cmd_ok && cmd == SBL_CMD_REF &&
                             &idle_vec) begin
                    g_next = SBL_G_REF;
                    gcnt_next = I_TIMING.refresh_cycle_wait;
                end else if (cmd_ok && cmd == SBL_CMD_LMR &&
                             &idle_vec) begin
                    g_next = SBL_G_MODE;
                    gcnt_next = I_TIMING.mode_load_wait;
                end
            end
            SBL_G_REF, SBL_G_MODE, SBL_G_XSR: begin
                // every command ignored until the wait runs out
                if (gcnt_reg <= 8'h01) begin
                    g_next = SBL_G_RUN;
                    gcnt_next = '0;
                end else begin
                    gcnt_next = gcnt_reg - 8'h01;
                end
            end
        endcase
        if (burst_start) begin
            last_bank_next = I_CMD.bank;
            last_valid_next = 1'b1;
        end else if (cmd_ok && cmd == SBL_CMD_BST) begin
            last_valid_next = 1'b0;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            cke_reg <= 1'b0;
            g_reg <= SBL_G_RUN;
            gcnt_reg <= '0;
            last_bank_reg <= 2'h0;
            last_valid_reg <= 1'b0;
            taken_reg <= 1'b0;
            code_reg <= SBL_CMD_NOP;
        end else begin
            cke_reg <= cke_next;
            g_reg <= g_next;
            gcnt_reg <= gcnt_next;
            last_bank_reg <= last_bank_next;
            last_valid_reg <= last_valid_next;
            taken_reg <= taken_next;
            code_reg <= code_next;
        end
    end

    // one state machine and wait counter per bank
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        logic hit;
        logic pre_hit;
        logic other_burst;
        logic bst_hit;
        logic done;
        assign hit = cmd_ok && (I_CMD.bank == 2'(b));
        assign pre_hit = cmd_ok && cmd == SBL_CMD_PRE &&
            (ap || I_CMD.bank == 2'(b));
        assign other_burst = burst_start && (I_CMD.bank != 2'(b));
        assign bst_hit = cmd_ok && cmd == SBL_CMD_BST && last_valid_reg &&
            last_bank_reg == 2'(b);
        assign done = cnt_reg[b] <= 8'h01;
        assign idle_vec[b] = (st_reg[b] == SBL_IDLE);

        always_comb begin
            st_next[b] = st_reg[b];
            cnt_next[b] = (cnt_reg[b] != '0) ? cnt_reg[b] - 8'h01 : '0;
            unique case (st_reg[b])
                SBL_IDLE: begin
                    // precharge to idle bank is a no-operation
                    if (hit && cmd == SBL_CMD_ACT) begin
                        st_next[b] = SBL_ACTV;
                        cnt_next[b] = I_TIMING.activate_to_access_wait;
                    end
                end
                SBL_ACTV, SBL_PRECH: begin
                    // busy: own counter, other banks unaffected
                    if (done) begin
                        st_next[b] = (st_reg[b] == SBL_ACTV) ?
                            SBL_ROWA : SBL_IDLE;
                    end
                end
                SBL_ROWA, SBL_RD, SBL_WR: begin
                    if (pre_hit) begin
                        st_next[b] = SBL_PRECH;
                        cnt_next[b] = I_TIMING.precharge_wait;
                    end else if (hit && cmd == SBL_CMD_READ) begin
                        st_next[b] = ap ? SBL_RDAP : SBL_RD;
                        cnt_next[b] = 8'(BURST_LEN);
                    end else if (hit && cmd == SBL_CMD_WRITE) begin
                        st_next[b] = ap ? SBL_WRAP : SBL_WR;
                        cnt_next[b] = 8'(BURST_LEN);
                    end else if (st_reg[b] != SBL_ROWA &&
                                 (bst_hit || done ||
                                  other_burst)) begin
                        st_next[b] = SBL_ROWA;
                    end
                end
                SBL_RDAP, SBL_WRAP: begin
                    // burst ends or is cut by another bank
                    if (done || other_burst) begin
                        st_next[b] = SBL_PRECH;
                        cnt_next[b] = I_TIMING.precharge_wait;
                    end
                end
                default: begin
                    st_next[b] = SBL_IDLE;
                end
            endcase
        end

        always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
            if (!I_RSTN) begin
                st_reg[b] <= SBL_IDLE;
                cnt_reg[b] <= '0;
            end else begin
                st_reg[b] <= st_next[b];
                cnt_reg[b] <= cnt_next[b];
            end
        end

        assign O_BANK_STATE[b*8 +: 8] = st_reg[b];

        chk_act_wait: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            (st_reg[b] == SBL_IDLE && hit && cmd == SBL_CMD_ACT) |=>
            st_reg[b] == SBL_ACTV)
            else $error("activate not taken");
        chk_pre_idle: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            (st_reg[b] == SBL_ROWA && pre_hit) |=>
            st_reg[b] == SBL_PRECH)
            else $error("precharge not taken");
        chk_idle_pre: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            (st_reg[b] == SBL_IDLE && !(hit && cmd == SBL_CMD_ACT)) |=>
            st_reg[b] == SBL_IDLE)
            else $error("idle bank left idle");
        chk_ap_cut: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            ((st_reg[b] == SBL_RDAP || st_reg[b] == SBL_WRAP) &&
             other_burst) |=> st_reg[b] == SBL_PRECH)
            else $error("concurrent auto precharge missed");
        chk_prech_end: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            (st_reg[b] == SBL_PRECH && done) |=>
            st_reg[b] == SBL_IDLE)
            else $error("precharge did not end in idle");
        chk_rd_trunc: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            (st_reg[b] == SBL_RD && hit && cmd == SBL_CMD_WRITE && !ap) |=>
            st_reg[b] == SBL_WR)
            else $error("write did not replace read");
        chk_rd_pre: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            (st_reg[b] == SBL_RD && pre_hit) |=>
            st_reg[b] == SBL_PRECH)
            else $error("precharge did not cut read");
        chk_wr_pre: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            (st_reg[b] == SBL_WR && pre_hit) |=>
            st_reg[b] == SBL_PRECH)
            else $error("precharge did not cut write");
        chk_wr_read: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            (st_reg[b] == SBL_WR && hit && cmd == SBL_CMD_READ && !ap) |=>
            st_reg[b] == SBL_RD)
            else $error("read did not replace write");
        chk_bst_stop: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            ((st_reg[b] == SBL_RD || st_reg[b] == SBL_WR) && bst_hit) |=>
            st_reg[b] == SBL_ROWA)
            else $error("burst terminate missed");
        chk_ap_hold: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            ((st_reg[b] == SBL_RDAP || st_reg[b] == SBL_WRAP) &&
             !done && !other_burst) |=> st_reg[b] == $past(st_reg[b]))
            else $error("auto precharge burst left early");
        chk_actv_hold: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            (st_reg[b] == SBL_ACTV && !done) |=>
            st_reg[b] == SBL_ACTV)
            else $error("activation ended early");
        chk_prech_hold: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            (st_reg[b] == SBL_PRECH && !done) |=>
            st_reg[b] == SBL_PRECH)
            else $error("precharge ended early");
        chk_prea_bank: assert property (@(posedge I_SYS_CLK)
            disable iff (!I_RSTN)
            (pre_hit && ap && (st_reg[b] == SBL_ROWA ||
             st_reg[b] == SBL_RD || st_reg[b] == SBL_WR)) |=>
            st_reg[b] == SBL_PRECH)
            else $error("precharge all missed a bank");
    end

    // outputs
    assign O_ALL_IDLE = &idle_vec && g_reg == SBL_G_RUN;
    assign O_BUSY = g_reg != SBL_G_RUN;
    assign O_CMD_TAKEN = taken_reg;
    assign O_CMD_CODE = code_reg;

    sequence s_refresh_start;
        cmd_ok && cmd == SBL_CMD_REF && &idle_vec && !I_SELF_REF_EXIT;
    endsequence
    chk_refresh_blk: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RSTN)
        s_refresh_start |=> O_BUSY [*1] ##0 !cmd_ok)
        else $error("refresh did not block commands");
    chk_cke_gate: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RSTN)
        !$past(I_CKE) |-> !cmd_ok)
        else $error("command taken with clock enable low");
    chk_deselect: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RSTN)
        I_CMD.cs_n |=> !O_CMD_TAKEN)
        else $error("deselected command was taken");

    // mode load and refresh both end with every bank idle
    sequence s_mode_start;
        cmd_ok && cmd == SBL_CMD_LMR && &idle_vec && !I_SELF_REF_EXIT;
    endsequence
    chk_mode_blk: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RSTN)
        s_mode_start |=> O_BUSY [*1] ##0 !cmd_ok)
        else $error("mode load did not block commands");
    chk_xsr_blk: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RSTN)
        (g_reg == SBL_G_RUN && I_SELF_REF_EXIT) |=> O_BUSY)
        else $error("self refresh exit wait not entered");
    chk_refresh_idle: assert property (@(posedge I_SYS_CLK)
        disable iff (!I_RSTN)
        (g_reg == SBL_G_REF && gcnt_reg <= 8'h01) |=> O_ALL_IDLE)
        else $error("refresh did not end all idle");
endmodule // sbl_bank_legality

/* test/sbl_ctrl_model.sv */
// Purpose: memory controller model driving the command bus
// Assumes: a command is held for exactly one rising edge
// Notes: released address and bank lines are inverted, never left stale
module sbl_ctrl_model
    import sbl_pkg::*;
(
    // clock
    input wire logic i_clk,
    // command bus to the device
    output logic o_cke,
    output sbl_cmd_bus_t o_cmd
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: deselected, clock enable high
    initial begin
        o_cke = 1'b1;
        o_cmd = {1'b1, 3'h7, 2'h0, 13'h0000};
    end

    // strobes {row, column, write}, active low
    function automatic logic [2:0] strobes(input sbl_cmd_t c);
        case (c)
            SBL_CMD_ACT: strobes = 3'h3;
            SBL_CMD_REF: strobes = 3'h1;
            SBL_CMD_LMR: strobes = 3'h0;
            SBL_CMD_PRE: strobes = 3'h2;
            SBL_CMD_READ: strobes = 3'h5;
            SBL_CMD_WRITE: strobes = 3'h4;
            SBL_CMD_BST: strobes = 3'h6;
            default: strobes = 3'h7;
        endcase
    endfunction

    // one command on one edge, then a no-operation; callers aim at
    // busy banks only when a refusal is meant
    task automatic send(input sbl_cmd_t c, input logic [1:0] b,
                        input logic ap, input logic sel, input logic ke);
        logic [2:0] s;
        s = strobes(c);
        @(posedge i_clk);
        o_cke <= ke;
        o_cmd <= {sel, s, b, 2'h0, ap, 10'h015};
        @(posedge i_clk);
        o_cke <= 1'b1;
        o_cmd <= {1'b0, 3'h7, ~b, ~o_cmd.addr};
    endtask
endmodule // sbl_ctrl_model

/* test/tb_top.sv */
// Purpose: self-checking bench for the bank command legality block
// Assumes: short wait counts so every state is seen within a few cycles
// Notes: checks are taken 1 ns after the registering edge
module tb_top
    import sbl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    logic clk;
    logic rstn;
    logic cke;
    logic sre;
    sbl_cmd_bus_t cmd;
    sbl_timing_t tim;
    logic [31:0] state;
    logic all_idle;
    logic busy;
    logic taken;
    logic [3:0] code;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    // device and its controller
    sbl_bank_legality #(.BURST_LEN(8)) dut (
        .I_SYS_CLK(clk), .I_RSTN(rstn), .I_CKE(cke), .I_CMD(cmd),
        .I_SELF_REF_EXIT(sre), .I_TIMING(tim), .O_BANK_STATE(state),
        .O_ALL_IDLE(all_idle), .O_BUSY(busy), .O_CMD_TAKEN(taken),
        .O_CMD_CODE(code));
    sbl_ctrl_model ctl (.i_clk(clk), .o_cke(cke), .o_cmd(cmd));

    task automatic stop_test;
        $display("checks %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] bk(input int b);
        bk = {24'h0, state[8*b +: 8]};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // issue one selected command and let its edge settle
    task automatic go(input sbl_cmd_t c, input logic [1:0] b, input logic ap);
        ctl.send(c, b, ap, 1'b0, 1'b1);
        #1;
    endtask

    task automatic t_reset;
        check(state, 32'h01010101);
        check({31'h0, all_idle}, 32'h1);
        check({31'h0, busy}, 32'h0);
        go(SBL_CMD_PRE, 2'h3, 1'b0);
        check(state, 32'h01010101);
        $display("t_reset done");
    endtask

    task automatic t_inhibit;
        ctl.send(SBL_CMD_ACT, 2'h0, 1'b0, 1'b1, 1'b1);
        #1;
        check(state, 32'h01010101);
        check({31'h0, taken}, 32'h0);
        ctl.send(SBL_CMD_ACT, 2'h0, 1'b0, 1'b0, 1'b0);
        #1;
        check(state, 32'h01010101);
        cyc(2);
        check(state, 32'h01010101);
        $display("t_inhibit done");
    endtask

    task automatic t_rw;
        go(SBL_CMD_ACT, 2'h1, 1'b0);
        check(bk(1), 32'h02);
        check({27'h0, taken, code}, 32'h11);
        cyc(1);
        check(bk(1), 32'h02);
        cyc(3);
        check(state, 32'h01010401);
        go(SBL_CMD_READ, 2'h1, 1'b0);
        check(bk(1), 32'h08);
        go(SBL_CMD_WRITE, 2'h1, 1'b0);
        check(bk(1), 32'h10);
        go(SBL_CMD_READ, 2'h1, 1'b0);
        check(bk(1), 32'h08);
        go(SBL_CMD_PRE, 2'h1, 1'b0);
        check(bk(1), 32'h80);
        cyc(1);
        check(bk(1), 32'h80);
        cyc(4);
        check(bk(1), 32'h01);
        go(SBL_CMD_ACT, 2'h1, 1'b0);
        cyc(3);
        go(SBL_CMD_WRITE, 2'h1, 1'b0);
        go(SBL_CMD_PRE, 2'h1, 1'b0);
        check(bk(1), 32'h80);
        cyc(5);
        check(bk(1), 32'h01);
        $display("t_rw done");
    endtask

    task automatic t_bst;
        go(SBL_CMD_ACT, 2'h0, 1'b0);
        cyc(3);
        go(SBL_CMD_WRITE, 2'h0, 1'b0);
        go(SBL_CMD_BST, 2'h0, 1'b0);
        check(bk(0), 32'h04);
        go(SBL_CMD_READ, 2'h0, 1'b0);
        go(SBL_CMD_BST, 2'h2, 1'b0);
        check(bk(0), 32'h04);
        check({28'h0, code}, 32'h7);
        $display("t_bst done");
    endtask

    task automatic t_ap;
        go(SBL_CMD_ACT, 2'h2, 1'b0);
        check(state, 32'h01020104);
        cyc(3);
        go(SBL_CMD_READ, 2'h0, 1'b1);
        check(bk(0), 32'h20);
        go(SBL_CMD_READ, 2'h2, 1'b0);
        check(bk(0), 32'h80);
        check(bk(2), 32'h08);
        cyc(10);
        check(state, 32'h01040101);
        go(SBL_CMD_WRITE, 2'h2, 1'b1);
        check(bk(2), 32'h40);
        cyc(1);
        check(bk(2), 32'h40);
        cyc(16);
        check(state, 32'h01010101);
        $display("t_ap done");
    endtask

    task automatic t_prea;
        go(SBL_CMD_ACT, 2'h0, 1'b0);
        cyc(3);
        go(SBL_CMD_ACT, 2'h1, 1'b0);
        cyc(3);
        go(SBL_CMD_PRE, 2'h3, 1'b1);
        check(state, 32'h01018080);
        check({31'h0, all_idle}, 32'h0);
        cyc(5);
        check({all_idle, state[30:0]}, 32'h81010101);
        $display("t_prea done");
    endtask

    task automatic t_ref;
        go(SBL_CMD_REF, 2'h0, 1'b0);
        check({31'h0, busy}, 32'h1);
        go(SBL_CMD_ACT, 2'h0, 1'b0);
        check(bk(0), 32'h01);
        cyc(6);
        check({busy, all_idle, state[29:0]}, 32'h41010101);
        go(SBL_CMD_LMR, 2'h0, 1'b0);
        check({31'h0, busy}, 32'h1);
        cyc(3);
        check({busy, all_idle, state[29:0]}, 32'h41010101);
        @(posedge clk);
        sre <= 1'b1;
        @(posedge clk);
        sre <= 1'b0;
        #1;
        check({31'h0, busy}, 32'h1);
        cyc(6);
        check({30'h0, busy, all_idle}, 32'h1);
        $display("t_ref done");
    endtask

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard: the whole run needs well under 1000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            $display("ERROR at %0t: timeout", $time);
            stop_test();
        end
    end

    // main sequence
    initial begin
        rstn = 1'b0;
        sre = 1'b0;
        tim = {8'h03, 8'h02, 8'h05, 8'h02, 8'h04};
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        cyc(3);
        t_reset();
        t_inhibit();
        t_rw();
        t_bst();
        t_ap();
        t_prea();
        t_ref();
        stop_test();
    end
endmodule // tb_top
